// [hw/cws_pkg.sv]
// package: register map, field layout and state types of the waveform steering/shutdown block
package cws_pkg;
   localparam int AXI_AW = 8;
   localparam int DB_W = 6;
   localparam int NLANE = 4;
   localparam int NSRC = 6;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [AXI_AW-1:0] OFF_STEER = 8'h00;
   localparam logic [AXI_AW-1:0] OFF_SD_CTRL = 8'h04;
   localparam logic [AXI_AW-1:0] OFF_SRC_EN = 8'h08;
   localparam logic [AXI_AW-1:0] OFF_RISE_DB = 8'h0c;
   localparam logic [AXI_AW-1:0] OFF_FALL_DB = 8'h10;
   localparam logic [AXI_AW-1:0] OFF_CTRL = 8'h14;
   localparam logic [AXI_AW-1:0] OFF_POL = 8'h18;
   localparam logic [AXI_AW-1:0] OFF_IRQ_STS = 8'h1c;
   localparam logic [AXI_AW-1:0] OFF_IRQ_MASK = 8'h20;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SD_BIT = 7;
   localparam int REN_BIT = 6;
   localparam int LVL_BD_LSB = 4;
   localparam int LVL_AC_LSB = 2;
   localparam int EN_BIT = 7;
   localparam int IN_BIT = 5;
   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic [1:0] LVL_RESET = 2'h1;
   localparam logic [1:0] LVL_ONE = 2'h3;
   localparam logic [1:0] LVL_ZERO = 2'h2;
   localparam logic [1:0] LVL_TRI = 2'h1;
   localparam logic [1:0] LVL_INACTIVE = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      MODE_ASYNC_STEER = 3'b000,
      MODE_SYNC_STEER = 3'b001,
      MODE_FWD_BRIDGE = 3'b010,
      MODE_REV_BRIDGE = 3'b011,
      MODE_HALF_BRIDGE = 3'b100,
      MODE_PUSH_PULL = 3'b101,
      MODE_RSVD6 = 3'b110,
      MODE_RSVD7 = 3'b111
   } cws_mode_t;
   // ----------------------------------------------------------------
   // state carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NLANE-1:0] override_level;
      logic [NLANE-1:0] steer_enable;
      logic ren;
      logic [1:0] shutdown_level_bd;
      logic [1:0] shutdown_level_ac;
      logic [NSRC-1:0] src_en;
      logic [DB_W-1:0] rise_deadband_count;
      logic [DB_W-1:0] fall_deadband_count;
      logic en;
      cws_mode_t mode;
      logic [NLANE-1:0] invert_out;
      logic irq_sts;
      logic irq_mask;
   } cws_regs_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [AXI_AW-1:0] waddr;
      logic [7:0] wdata;
      logic wlane0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } cws_axi_t;
   typedef struct packed {
      cws_regs_t r;
      cws_axi_t b;
      logic shutdown;
      logic freeze;
      logic data_q;
      logic db_wave;
      logic [DB_W-1:0] rise_cnt;
      logic [DB_W-1:0] fall_cnt;
      logic [DB_W-1:0] sd_cnt;
      logic [NLANE-1:0] steer_act;
      logic [NLANE-1:0] out;
      logic [NLANE-1:0] oe;
      logic irq;
   } cws_state_t;
endpackage

// [hw/cws_top.sv]
// module: steering, auto-shutdown and dead-band stage with an axi4-lite register slave
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module cws_top
   import cws_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_data,
   input wire logic [NSRC-1:0] i_shutdown_src,
   input wire logic [AXI_AW-1:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [AXI_AW-1:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   output logic [NLANE-1:0] o_drive_out,
   output logic [NLANE-1:0] o_drive_oe,
   output logic o_irq
);
   cws_state_t st_q;
   cws_state_t st_d;
   logic [NSRC-1:0] src_active;
   logic any_active;
   logic rise_edge;
   logic fall_edge;
   logic steer_mode;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic wr_fire;
   logic sw_sd_one;
   logic sw_sd_zero;

   // ----------------------------------------------------------------
   // shared decode
   // ----------------------------------------------------------------
   assign src_active = i_shutdown_src & st_q.r.src_en;
   assign any_active = |src_active;
   assign rise_edge = i_data & ~st_q.data_q;
   assign fall_edge = ~i_data & st_q.data_q;
   assign steer_mode = (st_q.r.mode == MODE_ASYNC_STEER) || (st_q.r.mode == MODE_SYNC_STEER);
   assign aw_hs = i_s_axi_awvalid & st_q.b.awready;
   assign w_hs = i_s_axi_wvalid & st_q.b.wready;
   assign ar_hs = i_s_axi_arvalid & st_q.b.arready;
   assign wr_fire = st_q.b.aw_got & st_q.b.w_got & ~st_q.b.bvalid;
   assign sw_sd_one = wr_fire && st_q.b.wlane0 && (st_q.b.waddr == OFF_SD_CTRL)
      && st_q.b.wdata[SD_BIT];
   assign sw_sd_zero = wr_fire && st_q.b.wlane0 && (st_q.b.waddr == OFF_SD_CTRL)
      && !st_q.b.wdata[SD_BIT];

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [1:0] lvl;
      logic normal;
      lvl = 2'h0;
      normal = 1'b0;
      st_d = st_q;
      st_d.data_q = i_data;

      // write channel: address and data taken in either order
      if (aw_hs)
      begin
         st_d.b.aw_got = 1'b1;
         st_d.b.waddr = i_s_axi_awaddr;
      end
      if (w_hs)
      begin
         st_d.b.w_got = 1'b1;
         st_d.b.wdata = i_s_axi_wdata[7:0];
         st_d.b.wlane0 = i_s_axi_wstrb[0];
      end
      if (st_q.b.bvalid && i_s_axi_bready)
         st_d.b.bvalid = 1'b0;
      if (wr_fire)
      begin
         st_d.b.aw_got = 1'b0;
         st_d.b.w_got = 1'b0;
         st_d.b.bvalid = 1'b1;
         st_d.b.bresp = RESP_OKAY;
         unique case (st_q.b.waddr)
            OFF_STEER:
            begin
               if (st_q.b.wlane0)
               begin
                  st_d.r.override_level = st_q.b.wdata[7:4];
                  st_d.r.steer_enable = st_q.b.wdata[3:0];
               end
            end
            OFF_SD_CTRL:
            begin
               if (st_q.b.wlane0)
               begin
                  st_d.r.ren = st_q.b.wdata[REN_BIT];
                  st_d.r.shutdown_level_bd = st_q.b.wdata[LVL_BD_LSB+:2];
                  st_d.r.shutdown_level_ac = st_q.b.wdata[LVL_AC_LSB+:2];
               end
            end
            OFF_SRC_EN:
            begin
               if (st_q.b.wlane0)
                  st_d.r.src_en = st_q.b.wdata[NSRC-1:0];
            end
            OFF_RISE_DB:
            begin
               if (st_q.b.wlane0)
                  st_d.r.rise_deadband_count = st_q.b.wdata[DB_W-1:0];
            end
            OFF_FALL_DB:
            begin
               if (st_q.b.wlane0)
                  st_d.r.fall_deadband_count = st_q.b.wdata[DB_W-1:0];
            end
            OFF_CTRL:
            begin
               if (st_q.b.wlane0)
               begin
                  st_d.r.en = st_q.b.wdata[EN_BIT];
                  st_d.r.mode = cws_mode_t'(st_q.b.wdata[2:0]);
               end
            end
            OFF_POL:
            begin
               if (st_q.b.wlane0)
                  st_d.r.invert_out = st_q.b.wdata[3:0];
            end
            OFF_IRQ_STS:
            begin
               // read-to-clear only; writes have no effect
            end
            OFF_IRQ_MASK:
            begin
               if (st_q.b.wlane0)
                  st_d.r.irq_mask = st_q.b.wdata[0];
            end
            default:
               st_d.b.bresp = RESP_SLVERR;
         endcase
      end
      st_d.b.awready = ~st_d.b.aw_got & ~st_d.b.bvalid;
      st_d.b.wready = ~st_d.b.w_got & ~st_d.b.bvalid;

      // read channel: one outstanding read, answer the cycle after the address
      if (st_q.b.rvalid && i_s_axi_rready)
         st_d.b.rvalid = 1'b0;
      if (ar_hs)
      begin
         st_d.b.rvalid = 1'b1;
         st_d.b.rresp = RESP_OKAY;
         st_d.b.rdata = 8'h00;
         unique case (i_s_axi_araddr)
            OFF_STEER:
               st_d.b.rdata = {st_q.r.override_level, st_q.r.steer_enable};
            OFF_SD_CTRL:
               st_d.b.rdata = {st_q.shutdown, st_q.r.ren, st_q.r.shutdown_level_bd,
                  st_q.r.shutdown_level_ac, 2'h0};
            OFF_SRC_EN:
               st_d.b.rdata = {2'h0, st_q.r.src_en};
            OFF_RISE_DB:
               st_d.b.rdata = {2'h0, st_q.r.rise_deadband_count};
            OFF_FALL_DB:
               st_d.b.rdata = {2'h0, st_q.r.fall_deadband_count};
            OFF_CTRL:
               st_d.b.rdata = {st_q.r.en, 4'h0, st_q.r.mode};
            OFF_POL:
               st_d.b.rdata = {2'h0, st_q.data_q, 1'b0, st_q.r.invert_out};
            OFF_IRQ_STS:
            begin
               st_d.b.rdata = {7'h00, st_q.r.irq_sts};
               st_d.r.irq_sts = 1'b0;
            end
            OFF_IRQ_MASK:
               st_d.b.rdata = {7'h00, st_q.r.irq_mask};
            default:
               st_d.b.rresp = RESP_SLVERR;
         endcase
      end
      st_d.b.arready = ~st_d.b.rvalid;

      // shutdown status: a set always beats any clear in the same cycle
      if (any_active || sw_sd_one)
         st_d.shutdown = 1'b1;
      else if (sw_sd_zero)
         st_d.shutdown = 1'b0;
      else if (st_q.r.ren)
         st_d.shutdown = 1'b0;
      if (st_d.shutdown && !st_q.shutdown)
         st_d.r.irq_sts = 1'b1;

      // outputs stay frozen until a data rise after the status clears
      if (st_d.shutdown)
         st_d.freeze = 1'b1;
      else if (rise_edge)
         st_d.freeze = 1'b0;
      if (st_d.shutdown && !st_q.freeze)
         st_d.sd_cnt = st_q.r.fall_deadband_count;
      else if (st_q.sd_cnt != 6'h00)
         st_d.sd_cnt = st_q.sd_cnt - 6'h01;

      // dead-band: each counter reloads on its own edge and cancels the other
      if (st_q.rise_cnt != 6'h00)
      begin
         st_d.rise_cnt = st_q.rise_cnt - 6'h01;
         if (st_q.rise_cnt == 6'h01)
            st_d.db_wave = 1'b1;
      end
      if (st_q.fall_cnt != 6'h00)
      begin
         st_d.fall_cnt = st_q.fall_cnt - 6'h01;
         if (st_q.fall_cnt == 6'h01)
            st_d.db_wave = 1'b0;
      end
      if (rise_edge)
      begin
         st_d.fall_cnt = 6'h00;
         st_d.rise_cnt = st_q.r.rise_deadband_count;
         if (st_q.r.rise_deadband_count == 6'h00)
            st_d.db_wave = 1'b1;
      end
      if (fall_edge)
      begin
         st_d.rise_cnt = 6'h00;
         st_d.fall_cnt = st_q.r.fall_deadband_count;
         if (st_q.r.fall_deadband_count == 6'h00)
            st_d.db_wave = 1'b0;
      end

      // steering enables: immediate in async mode, taken at data rise in sync mode
      if (st_q.r.mode == MODE_ASYNC_STEER)
         st_d.steer_act = st_q.r.steer_enable;
      else if (st_q.r.mode == MODE_SYNC_STEER && rise_edge)
         st_d.steer_act = st_q.r.steer_enable;

      // per-lane output selection
      for (int i = 0; i < NLANE; i++)
      begin
         // bridge modes live in another stage; here they show the inactive level
         if (st_q.r.en && steer_mode)
            normal = st_q.steer_act[i] ? (st_q.db_wave ^ st_q.r.invert_out[i])
               : st_q.r.override_level[i];
         else
            normal = st_q.r.invert_out[i];
         lvl = (i % 2 == 0) ? st_q.r.shutdown_level_ac : st_q.r.shutdown_level_bd;
         st_d.oe[i] = 1'b1;
         if (!st_q.freeze)
            st_d.out[i] = normal;
         else
         begin
            unique case (lvl)
               LVL_ONE: st_d.out[i] = 1'b1;
               LVL_ZERO: st_d.out[i] = 1'b0;
               LVL_TRI: st_d.oe[i] = 1'b0;
               LVL_INACTIVE:
               begin
                  if (st_q.sd_cnt == 6'h00)
                     st_d.out[i] = st_q.r.invert_out[i];
               end
            endcase
         end
      end
      st_d.irq = |(st_d.r.irq_sts & st_d.r.irq_mask);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         st_q <= '0;
         st_q.r.shutdown_level_bd <= LVL_RESET;
         st_q.r.shutdown_level_ac <= LVL_RESET;
         st_q.b.awready <= 1'b1;
         st_q.b.wready <= 1'b1;
         st_q.b.arready <= 1'b1;
      end
      else
         st_q <= st_d;
   end

   assign o_s_axi_awready = st_q.b.awready;
   assign o_s_axi_wready = st_q.b.wready;
   assign o_s_axi_bvalid = st_q.b.bvalid;
   assign o_s_axi_bresp = st_q.b.bresp;
   assign o_s_axi_arready = st_q.b.arready;
   assign o_s_axi_rvalid = st_q.b.rvalid;
   assign o_s_axi_rdata = {24'h000000, st_q.b.rdata};
   assign o_s_axi_rresp = st_q.b.rresp;
   assign o_drive_out = st_q.out;
   assign o_drive_oe = st_q.oe;
   assign o_irq = st_q.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);

   sequence sd_entry_s;
      !st_q.shutdown ##1 st_q.shutdown;
   endsequence
   sequence lane_a_steered_s;
      st_q.r.en && !st_q.freeze && steer_mode;
   endsequence

   steer_pass_a: assert property (
      lane_a_steered_s and st_q.steer_act[0] |=> st_q.out[0] == $past(st_q.db_wave
      ^ st_q.r.invert_out[0]))
      else $error("steered lane a does not follow data");
   override_a: assert property (
      lane_a_steered_s and !st_q.steer_act[0] |=> st_q.out[0] == $past(st_q.r.override_level[0]))
      else $error("lane a does not show its override level");
   sync_buffer_a: assert property (
      st_q.r.mode == MODE_SYNC_STEER && !rise_edge |=> $stable(st_q.steer_act))
      else $error("steering enables changed between data rises");
   src_shutdown_a: assert property (
      any_active |=> st_q.shutdown && st_q.freeze)
      else $error("active enabled source did not shut down");
   manual_hold_a: assert property (
      st_q.shutdown && !st_q.r.ren && !sw_sd_zero |=> st_q.shutdown)
      else $error("status left shutdown without software clear");
   auto_clear_a: assert property (
      st_q.shutdown && st_q.r.ren && !any_active && !sw_sd_one |=> !st_q.shutdown)
      else $error("auto restart did not clear status");
   freeze_hold_a: assert property (
      st_q.freeze && !rise_edge |=> st_q.freeze)
      else $error("outputs resumed without a data rise");
   level_one_a: assert property (
      st_q.freeze && st_q.r.shutdown_level_ac == LVL_ONE |=> st_q.out[2] && st_q.oe[2])
      else $error("lane c not driven high in shutdown");
   tristate_a: assert property (
      st_q.freeze && st_q.r.shutdown_level_bd == LVL_TRI |=> !st_q.oe[1] && !st_q.oe[3])
      else $error("lanes b and d not released in shutdown");
   rise_delay_a: assert property (
      rise_edge && !st_q.db_wave && st_q.r.rise_deadband_count == 6'h03 ##1 i_data [*3]
      |=> st_q.db_wave && !$past(st_q.db_wave))
      else $error("rising dead-band of three is wrong");
   fall_bypass_a: assert property (
      fall_edge && st_q.r.fall_deadband_count == 6'h00 |=> !st_q.db_wave)
      else $error("zero falling count did not bypass");
   irq_flag_a: assert property (
      sd_entry_s |-> st_q.r.irq_sts)
      else $error("shutdown event did not set the flag");
endmodule

// [verification/cws_bridge_model.sv]
// model of the external bridge driver stage that the four lanes feed
`timescale 1ns/1ns
module cws_bridge_model
   import cws_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic [NLANE-1:0] i_drive_out,
   input wire logic [NLANE-1:0] i_drive_oe,
   output logic [NLANE-1:0] o_pin
);
   logic [NLANE-1:0] float_q = '0;
   // the pins have no pull, so an undriven pin wanders instead of keeping its last level
   always @(posedge i_clk_sys)
      float_q <= ~float_q;
   assign o_pin = (i_drive_out & i_drive_oe) | (float_q & ~i_drive_oe);
endmodule

// [verification/cws_top_test.sv]
// self-checking bench for the steering, shutdown and dead-band stage
`timescale 1ns/1ns
module cws_top_test;
   import cws_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst, data, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [NSRC-1:0] src;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rdv;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   logic [3:0] dout, doe, pin;
   int n_errors = 0;
   int samples_checked = 0;
   always #50 clk = ~clk;
   cws_top dut (.i_clk_sys(clk), .i_reset(rst), .i_data(data), .i_shutdown_src(src),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
      .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_drive_out(dout),
      .o_drive_oe(doe), .o_irq(irq));
   cws_bridge_model drv (.i_clk_sys(clk), .i_drive_out(dout), .i_drive_oe(doe), .o_pin(pin));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // ready is looked at on the falling edge, where it already holds its value for the next rise
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ra, rw, rb;
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do
      begin
         @(negedge clk);
         ra = awready & awvalid;
         rw = wready & wvalid;
         rb = bvalid & bready;
         rsp = bresp;
         @(posedge clk);
         n++;
         if (ra)
            awvalid <= 1'b0;
         if (rw)
            wvalid <= 1'b0;
      end
      while (!rb && n < 100);
      bready <= 1'b0;
      if (!rb)
      begin
         n_errors++;
         $display("[FAIL] %0t ns: write response timed out", $time);
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic ra, rv;
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do
      begin
         @(negedge clk);
         ra = arready & arvalid;
         rv = rvalid & rready;
         d = rdata;
         rsp = rresp;
         @(posedge clk);
         n++;
         if (ra)
            arvalid <= 1'b0;
      end
      while (!rv && n < 100);
      rready <= 1'b0;
      if (!rv)
      begin
         n_errors++;
         $display("[FAIL] %0t ns: read response timed out", $time);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      rd(a, rdv);
      chk(rdv, {24'h0, e});
   endtask
   task automatic lanes(input int w, input logic [3:0] lv, input logic [3:0] oe);
      repeat (w) @(posedge clk);
      @(negedge clk);
      chk({28'h0, doe}, {28'h0, oe});
      chk({28'h0, pin & oe}, {28'h0, lv & oe});
      @(posedge clk);
   endtask
   task automatic irqchk(input logic e);
      @(negedge clk);
      chk({31'h0, irq}, {31'h0, e});
      @(posedge clk);
   endtask
   // counts falling edges from a data change until lane a follows it
   task automatic lat(input logic v, output int n);
      data <= v;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (pin[0] !== v && n < 200);
      @(posedge clk);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      logic [7:0] ad [9] = '{OFF_STEER, OFF_SD_CTRL, OFF_SRC_EN, OFF_RISE_DB, OFF_FALL_DB,
         OFF_CTRL, OFF_POL, OFF_IRQ_STS, OFF_IRQ_MASK};
      logic [7:0] ex [9] = '{8'h00, 8'h14, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      foreach (ad[i])
         rdc(ad[i], ex[i]);
      rdc(8'h24, 8'h00);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(8'h24, 8'hff);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(OFF_RISE_DB, 8'hff);
      rdc(OFF_RISE_DB, 8'h3f);
      wr(OFF_SRC_EN, 8'hff);
      rdc(OFF_SRC_EN, 8'h3f);
      wr(OFF_IRQ_STS, 8'h01);
      rdc(OFF_IRQ_STS, 8'h00);
      @(posedge clk) data <= 1'b1;
      rdc(OFF_POL, 8'h20);
      @(posedge clk) data <= 1'b0;
      wr(OFF_SRC_EN, 8'h00);
      wr(OFF_RISE_DB, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_steer();
      wr(OFF_POL, 8'h01);
      wr(OFF_STEER, 8'h25);
      wr(OFF_CTRL, 8'h80);
      @(posedge clk) data <= 1'b1;
      lanes(4, 4'b0110, 4'hf);
      @(posedge clk) data <= 1'b0;
      lanes(4, 4'b0011, 4'hf);
      for (int m = 2; m < 8; m++)
      begin
         wr(OFF_CTRL, 8'h80 | 8'(m));
         lanes(4, 4'b0001, 4'hf);
      end
      wr(OFF_POL, 8'h00);
      wr(OFF_STEER, 8'h01);
      wr(OFF_CTRL, 8'h81);
      @(posedge clk) data <= 1'b1;
      lanes(4, 4'b0001, 4'hf);
      wr(OFF_STEER, 8'h00);
      lanes(4, 4'b0001, 4'hf);
      @(posedge clk) data <= 1'b0;
      lanes(4, 4'b0000, 4'hf);
      @(posedge clk) data <= 1'b1;
      lanes(4, 4'b0000, 4'hf);
      @(posedge clk) data <= 1'b0;
      $display("test steering done");
   endtask
   task automatic t_db();
      int r0, f0, r1, f1;
      wr(OFF_STEER, 8'h0f);
      wr(OFF_CTRL, 8'h80);
      lat(1'b1, r0);
      lat(1'b0, f0);
      chk({31'h0, r0 <= 4 && f0 <= 4}, 32'h1);
      wr(OFF_RISE_DB, 8'h03);
      wr(OFF_FALL_DB, 8'h3f);
      lat(1'b1, r1);
      lat(1'b0, f1);
      chk({31'h0, r1 - r0 >= 3 && r1 - r0 <= 4}, 32'h1);
      chk({31'h0, f1 - f0 >= 63 && f1 - f0 <= 64}, 32'h1);
      $display("test deadband done");
   endtask
   task automatic t_sd_auto();
      wr(OFF_FALL_DB, 8'h00);
      wr(OFF_RISE_DB, 8'h00);
      wr(OFF_SD_CTRL, 8'h6c);
      for (int i = 0; i < 6; i++)
      begin
         wr(OFF_SRC_EN, 8'h01 << i);
         @(posedge clk) src <= 6'h01 << ((i + 1) % 6);
         repeat (4) @(posedge clk);
         rdc(OFF_SD_CTRL, 8'h6c);
         @(posedge clk) src <= 6'h01 << i;
         lanes(4, 4'b0101, 4'hf);
         rdc(OFF_SD_CTRL, 8'hec);
         @(posedge clk) src <= 6'h00;
         repeat (4) @(posedge clk);
         rdc(OFF_SD_CTRL, 8'h6c);
         lanes(0, 4'b0101, 4'hf);
         @(posedge clk) data <= 1'b1;
         lanes(4, 4'b1111, 4'hf);
         @(posedge clk) data <= 1'b0;
      end
      $display("test auto restart done");
   endtask
   task automatic t_sd_sw();
      wr(OFF_IRQ_MASK, 8'h01);
      rdc(OFF_IRQ_STS, 8'h01);
      irqchk(1'b0);
      wr(OFF_SD_CTRL, 8'h38);
      wr(OFF_SRC_EN, 8'h01);
      @(posedge clk) src <= 6'h01;
      lanes(4, 4'b1010, 4'hf);
      irqchk(1'b1);
      rdc(OFF_IRQ_STS, 8'h01);
      irqchk(1'b0);
      wr(OFF_SD_CTRL, 8'h38);
      rdc(OFF_SD_CTRL, 8'hb8);
      @(posedge clk) src <= 6'h00;
      repeat (4) @(posedge clk);
      rdc(OFF_SD_CTRL, 8'hb8);
      wr(OFF_SD_CTRL, 8'h38);
      rdc(OFF_SD_CTRL, 8'h38);
      lanes(0, 4'b1010, 4'hf);
      @(posedge clk) data <= 1'b1;
      lanes(4, 4'b1111, 4'hf);
      @(posedge clk) data <= 1'b0;
      $display("test software restart done");
   endtask
   task automatic t_sd_dis();
      // level 00 holds the running level for the falling dead-band, then goes inactive
      @(posedge clk) data <= 1'b1;
      wr(OFF_FALL_DB, 8'h08);
      wr(OFF_SD_CTRL, 8'h80);
      lanes(0, 4'b1111, 4'hf);
      lanes(4, 4'b1111, 4'hf);
      lanes(8, 4'b0000, 4'hf);
      wr(OFF_SD_CTRL, 8'h00);
      @(posedge clk) data <= 1'b0;
      wr(OFF_CTRL, 8'h00);
      wr(OFF_POL, 8'h05);
      wr(OFF_FALL_DB, 8'h02);
      wr(OFF_SD_CTRL, 8'h90);
      lanes(8, 4'b0101, 4'b0101);
      rdc(OFF_SD_CTRL, 8'h90);
      wr(OFF_SD_CTRL, 8'h84);
      lanes(8, 4'b0000, 4'b1010);
      $display("test disabled shutdown done");
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("watchdog expired");
      finish_test();
   end
   initial
   begin
      rst = 1'b1;
      data = 1'b0;
      src = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_steer();
      t_db();
      t_sd_auto();
      t_sd_sw();
      t_sd_dis();
      finish_test();
   end
endmodule
